// ### logic/uart_fifo_frame_ctrl.sv
// Serial port queue configuration, character framing and line engine
// ==========================================================
// Function
// - FIFO config bit 0 turns queue mode off or on; reset off.
// - Writing 1 to FIFO config bit 1 empties receive queue; self-clearing.
// - Writing 1 to FIFO config bit 2 empties transmit queue; self-clearing.
// - Enhanced transmit threshold by bits 5:4: 16, 32, middle level, 112.
// - Receive threshold by bits 7:6: 1/4/8/14, enhanced 15/31/63/111.
// - FIFO config sits at offset 02h and is write-only.
// - Reads at offset 02h return the interrupt identification value.
// - Framing register at offset 03h is readable and writable.
// - Framing bits 1:0 give five to eight data bits.
// - Framing bit 6 holds the serial output at space for a break.
// - Framing bit 7 steers low offsets to the divisor latch.
// - Data read pops the oldest received character; empty reads return 00h.
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module uart_fifo_frame_ctrl #(
  parameter int DEPTH = 128,
  parameter int AW = 7,
  parameter logic [7:0] TX_ENH_LVL_2 = 8'h40
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [uart_cfg_pkg::HADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [uart_cfg_pkg::HDATA_W-1:0] hwdata,
  output logic [uart_cfg_pkg::HDATA_W-1:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rxd,
  output logic txd,
  output logic rx_trigger,
  output logic tx_trigger
);
  import uart_cfg_pkg::*;

  function automatic reg_sel_e decode_sel(input logic [IDX_W-1:0] idx,
                                          input logic dlab);
    case (idx)
      IDX_DATA: decode_sel = dlab ? SEL_DLL : SEL_DATA;
      IDX_DIV_HI: decode_sel = dlab ? SEL_DLM : SEL_NONE;
      IDX_FIFO: decode_sel = SEL_FIFO;
      IDX_FRAME: decode_sel = SEL_FRAME;
      IDX_MODE: decode_sel = SEL_MODE;
      IDX_RX_COUNT: decode_sel = SEL_RXCNT;
      IDX_TX_COUNT: decode_sel = SEL_TXCNT;
      default: decode_sel = SEL_NONE;
    endcase
  endfunction : decode_sel

  function automatic logic [7:0] pick_lvl(input logic [1:0] code,
    input logic [7:0] l0, input logic [7:0] l1,
    input logic [7:0] l2, input logic [7:0] l3);
    case (code)
      2'h0: pick_lvl = l0;
      2'h1: pick_lvl = l1;
      2'h2: pick_lvl = l2;
      default: pick_lvl = l3;
    endcase
  endfunction : pick_lvl

  localparam logic [AW:0] CAP_FULL = (AW+1)'(DEPTH);
  localparam logic [AW:0] CAP_ONE = (AW+1)'(1);

  logic dp_valid_reg, dp_write_reg, rd_ready_reg;
  logic [IDX_W-1:0] dp_idx_reg;
  logic [7:0] hrdata_reg, frame_reg, div_lo_reg, div_hi_reg;
  logic fifo_en_reg, enh_reg, rx_trig_reg, tx_trig_reg;
  logic [1:0] tx_lvl_reg, rx_lvl_reg;
  logic rxd_s1_reg, rxd_s2_reg, txd_reg, tx_par_reg;
  tx_state_e tx_state;
  rx_state_e rx_state;
  logic [15:0] tx_tmr_reg, rx_tmr_reg;
  logic [7:0] tx_sh_reg, rx_sh_reg;
  logic [2:0] tx_n_reg, rx_n_reg, tx_half_reg;
  wire [1:0] push, pop, flush, full, empty;
  wire [AW:0] count [2];
  wire [7:0] qin [2];
  wire [7:0] qout [2];

  // ==========================================================
  // Bus slave: writes finish in one cycle, reads take one wait state
  wire rd_wait = dp_valid_reg & ~dp_write_reg & ~rd_ready_reg;
  wire rd_fire = ce & rd_wait;
  wire wr_fire = ce & hready & dp_valid_reg & dp_write_reg;
  wire [7:0] wbyte = hwdata[7:0];
  reg_sel_e sel;
  assign sel = decode_sel(dp_idx_reg, frame_reg[FR_DLAB]);
  wire wr_fifo = wr_fire & (sel == SEL_FIFO);
  // Changing mode empties both queues, since capacity changes with it
  wire en_change = wr_fifo & (wbyte[FC_EN] != fifo_en_reg);

  assign hreadyout = ce & ~rd_wait;
  assign hresp = 1'b0;
  assign hrdata = {24'h000000, hrdata_reg};

  wire [7:0] rx_head = empty[Q_RX] ? 8'h00 : qout[Q_RX];
  wire [7:0] iir_val = rx_trig_reg ? IIR_RX_DATA : IIR_NONE;
  wire [7:0] mode_rd = (8'(fifo_en_reg) << MODE_FIFO_ON) |
                       (8'(enh_reg) << MODE_ENH);
  wire [7:0] rd_byte =
    (sel == SEL_DATA) ? rx_head :
    (sel == SEL_DLL) ? div_lo_reg :
    (sel == SEL_DLM) ? div_hi_reg :
    (sel == SEL_FIFO) ? iir_val :
    (sel == SEL_FRAME) ? frame_reg :
    (sel == SEL_MODE) ? mode_rd :
    (sel == SEL_RXCNT) ? 8'(count[Q_RX]) :
    (sel == SEL_TXCNT) ? 8'(count[Q_TX]) : 8'h00;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_idx_reg <= '0;
      rd_ready_reg <= 1'b0;
      hrdata_reg <= 8'h00;
    end else if (ce) begin
      if (hready) begin
        dp_valid_reg <= hsel & htrans[1] & (hsize == SIZE_WORD);
        dp_write_reg <= hwrite;
        dp_idx_reg <= haddr[HADDR_W-1:2];
        rd_ready_reg <= 1'b0;
      end else if (rd_wait) begin
        rd_ready_reg <= 1'b1;
        hrdata_reg <= rd_byte;
      end
    end
  end

  // ==========================================================
  // Configuration registers
  wire [7:0] rx_thr = enh_reg ?
    pick_lvl(rx_lvl_reg, RX_ENH_0, RX_ENH_1, RX_ENH_2, RX_ENH_3) :
    pick_lvl(rx_lvl_reg, RX_STD_0, RX_STD_1, RX_STD_2, RX_STD_3);
  wire [7:0] tx_thr = enh_reg ?
    pick_lvl(tx_lvl_reg, TX_ENH_0, TX_ENH_1, TX_ENH_LVL_2, TX_ENH_3) :
    TX_STD_LVL;
  assign rx_trigger = rx_trig_reg;
  assign tx_trigger = tx_trig_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      frame_reg <= FRAME_RST;
      fifo_en_reg <= 1'b0;
      tx_lvl_reg <= LVL_RST;
      rx_lvl_reg <= LVL_RST;
      enh_reg <= 1'b0;
      div_lo_reg <= DIV_LO_RST;
      div_hi_reg <= DIV_HI_RST;
      rx_trig_reg <= 1'b0;
      tx_trig_reg <= 1'b0;
    end else if (ce) begin
      rx_trig_reg <= count[Q_RX] >= (AW+1)'(rx_thr);
      tx_trig_reg <= count[Q_TX] <= (AW+1)'(tx_thr);
      if (wr_fire) begin
        case (sel)
          SEL_FIFO: begin
            fifo_en_reg <= wbyte[FC_EN];
            tx_lvl_reg <= wbyte[FC_TXLVL +: 2];
            rx_lvl_reg <= wbyte[FC_RXLVL +: 2];
          end
          SEL_FRAME: frame_reg <= wbyte;
          SEL_DLL: div_lo_reg <= wbyte;
          SEL_DLM: div_hi_reg <= wbyte;
          SEL_MODE: enh_reg <= wbyte[MODE_ENH];
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // Receive and transmit queues
  wire [AW:0] cap = fifo_en_reg ? CAP_FULL : CAP_ONE;
  assign push[Q_TX] = wr_fire & (sel == SEL_DATA);
  assign qin[Q_TX] = wbyte;
  assign pop[Q_RX] = rd_fire & (sel == SEL_DATA);
  assign flush[Q_RX] = wr_fifo & (wbyte[FC_RXCLR] | en_change);
  assign flush[Q_TX] = wr_fifo & (wbyte[FC_TXCLR] | en_change);

  // Pointers wrap naturally, so DEPTH must be 2**AW
  for (genvar g = 0; g < 2; g++) begin : queue
    logic [AW-1:0] wp_reg, rp_reg;
    logic [AW:0] cnt_reg;
    wire do_push = push[g] & ~full[g];
    wire do_pop = pop[g] & ~empty[g];
    assign full[g] = (cnt_reg >= cap);
    assign empty[g] = (cnt_reg == '0);
    assign count[g] = cnt_reg;
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        wp_reg <= '0;
        rp_reg <= '0;
        cnt_reg <= '0;
      end else if (ce) begin
        if (flush[g]) begin
          wp_reg <= '0;
          rp_reg <= '0;
          cnt_reg <= '0;
        end else begin
          if (do_push) wp_reg <= wp_reg + 1'b1;
          if (do_pop) rp_reg <= rp_reg + 1'b1;
          cnt_reg <= cnt_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
      end
    end
    fifo_mem #(.W(8), .DEPTH(DEPTH), .AW(AW)) mem_i (
      .clk(clk), .rst_n(rst_n), .ce(ce),
      .we(do_push & ~flush[g]), .waddr(wp_reg), .wdata(qin[g]),
      .raddr(rp_reg), .rdata(qout[g])
    );
  end

  // ==========================================================
  // Framing decode and bit timing
  wire [15:0] divisor = {div_hi_reg, div_lo_reg};
  wire [15:0] bit_t = (divisor < DIV_MIN) ? DIV_MIN : divisor;
  wire [15:0] bit_last = bit_t - 16'h0001;
  wire [15:0] half_last = (bit_t >> 1) - 16'h0001;
  wire [1:0] len_code = frame_reg[FR_LEN +: 2];
  wire [2:0] last_bit = 3'(len_code) + DATA_MIN_LAST;
  wire [7:0] len_mask = 8'hFF >> (2'h3 - len_code);
  wire pen = frame_reg[FR_PEN];
  wire eps = frame_reg[FR_EPS];
  wire stick = frame_reg[FR_STICK];
  wire brk = frame_reg[FR_BRK];
  wire [2:0] stop_halves = !frame_reg[FR_STOP] ? STOP_HALF_ONE :
    ((len_code == LEN5) ? STOP_HALF_ONE_HALF : STOP_HALF_TWO);
  wire [7:0] tx_bits = qout[Q_TX] & len_mask;
  wire par_calc = stick ? ~eps : (eps ? ^tx_bits : ~^tx_bits);

  // ==========================================================
  // Transmitter
  wire tx_zero = (tx_tmr_reg == 16'h0000);
  wire tx_line = (tx_state == TX_START) ? 1'b0 :
                 (tx_state == TX_DATA) ? tx_sh_reg[0] :
                 (tx_state == TX_PAR) ? tx_par_reg : 1'b1;
  assign pop[Q_TX] = (tx_state == TX_LOAD);
  assign txd = txd_reg;

  // A break only masks the line; the character underneath still runs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_state <= TX_IDLE;
      tx_tmr_reg <= 16'h0000;
      tx_sh_reg <= 8'h00;
      tx_n_reg <= 3'h0;
      tx_half_reg <= 3'h0;
      tx_par_reg <= 1'b0;
      txd_reg <= 1'b1;
    end else if (ce) begin
      txd_reg <= ~brk & tx_line;
      if (!tx_zero) tx_tmr_reg <= tx_tmr_reg - 16'h0001;
      case (tx_state)
        TX_IDLE: if (!empty[Q_TX]) tx_state <= TX_LOAD;
        TX_LOAD: begin
          tx_sh_reg <= qout[Q_TX];
          tx_par_reg <= par_calc;
          tx_tmr_reg <= bit_last;
          tx_state <= TX_START;
        end
        TX_START: if (tx_zero) begin
          tx_tmr_reg <= bit_last;
          tx_n_reg <= last_bit;
          tx_state <= TX_DATA;
        end
        TX_DATA: if (tx_zero) begin
          tx_sh_reg <= tx_sh_reg >> 1;
          tx_tmr_reg <= bit_last;
          if (tx_n_reg != 3'h0) begin
            tx_n_reg <= tx_n_reg - 3'h1;
          end else if (pen) begin
            tx_state <= TX_PAR;
          end else begin
            tx_tmr_reg <= half_last;
            tx_half_reg <= stop_halves;
            tx_state <= TX_STOP;
          end
        end
        TX_PAR: if (tx_zero) begin
          tx_tmr_reg <= half_last;
          tx_half_reg <= stop_halves;
          tx_state <= TX_STOP;
        end
        TX_STOP: if (tx_zero) begin
          tx_tmr_reg <= half_last;
          tx_half_reg <= tx_half_reg - 3'h1;
          if (tx_half_reg == 3'h1) tx_state <= TX_IDLE;
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Receiver: start bit checked at mid-bit, then one sample per data and stop bit; parity is not sampled
  wire rx_zero = (rx_tmr_reg == 16'h0000);
  assign push[Q_RX] = (rx_state == RX_STOP) & rx_zero & rxd_s2_reg;
  assign qin[Q_RX] = rx_sh_reg >> (2'h3 - len_code);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rxd_s1_reg <= 1'b1;
      rxd_s2_reg <= 1'b1;
      rx_state <= RX_IDLE;
      rx_tmr_reg <= 16'h0000;
      rx_sh_reg <= 8'h00;
      rx_n_reg <= 3'h0;
    end else if (ce) begin
      rxd_s1_reg <= rxd;
      rxd_s2_reg <= rxd_s1_reg;
      if (!rx_zero) rx_tmr_reg <= rx_tmr_reg - 16'h0001;
      case (rx_state)
        RX_IDLE: if (!rxd_s2_reg) begin
          rx_tmr_reg <= half_last;
          rx_state <= RX_START;
        end
        RX_START: if (rx_zero) begin
          rx_tmr_reg <= bit_last;
          rx_n_reg <= last_bit;
          rx_state <= rxd_s2_reg ? RX_IDLE : RX_DATA;
        end
        RX_DATA: if (rx_zero) begin
          rx_sh_reg <= {rxd_s2_reg, rx_sh_reg[7:1]};
          rx_tmr_reg <= bit_last;
          if (rx_n_reg != 3'h0) rx_n_reg <= rx_n_reg - 3'h1;
          else rx_state <= pen ? RX_PAR : RX_STOP;
        end
        RX_PAR: if (rx_zero) begin
          rx_tmr_reg <= bit_last;
          rx_state <= RX_STOP;
        end
        RX_STOP: if (rx_zero) rx_state <= RX_IDLE;
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  fifo_enable_a: assert property (
    wr_fifo |=> fifo_en_reg == $past(wbyte[FC_EN]) &&
                (cap == (fifo_en_reg ? CAP_FULL : CAP_ONE)))
    else $error("queue mode bit not taken");
  rx_flush_a: assert property (
    wr_fifo && wbyte[FC_RXCLR] |=> count[Q_RX] == '0 &&
      (!flush[Q_RX] || wr_fifo))
    else $error("receive queue not emptied");
  tx_flush_a: assert property (
    wr_fifo && wbyte[FC_TXCLR] && !en_change |=> count[Q_TX] == '0 &&
      $stable(fifo_en_reg))
    else $error("transmit queue not emptied");
  tx_level_a: assert property (
    enh_reg && tx_lvl_reg == 2'h3 |-> tx_thr == TX_ENH_3)
    else $error("transmit threshold wrong");
  rx_level_a: assert property (
    (!enh_reg && rx_lvl_reg == 2'h3 |-> rx_thr == RX_STD_3) and
    (enh_reg && rx_lvl_reg == 2'h2 |-> rx_thr == RX_ENH_2))
    else $error("receive threshold wrong");
  fifo_wo_a: assert property (
    rd_fire && sel == SEL_FIFO |=> $stable(fifo_en_reg) &&
      $stable(rx_lvl_reg) && $stable(tx_lvl_reg))
    else $error("read changed queue settings");
  iir_read_a: assert property (
    rd_fire && sel == SEL_FIFO |=> hreadyout &&
      (hrdata_reg == IIR_NONE || hrdata_reg == IIR_RX_DATA))
    else $error("identification value wrong");
  frame_read_a: assert property (
    rd_fire && sel == SEL_FRAME |=> hrdata_reg == $past(frame_reg))
    else $error("framing readback wrong");
  data_bits_a: assert property (
    ce && tx_state == TX_START && tx_zero |=>
      tx_n_reg == 3'($past(len_code)) + DATA_MIN_LAST)
    else $error("data length wrong");
  stop_len_a: assert property (
    tx_state != TX_STOP ##1 tx_state == TX_STOP |->
      tx_half_reg >= STOP_HALF_ONE && tx_half_reg <= STOP_HALF_TWO)
    else $error("stop length wrong");
  parity_mark_a: assert property (
    ce && tx_state == TX_LOAD && stick && !eps |=> tx_par_reg)
    else $error("mark parity wrong");
  break_line_a: assert property (
    ce && brk |=> !txd)
    else $error("break not forced");
  dlab_read_a: assert property (
    rd_fire && dp_idx_reg == IDX_DATA && frame_reg[FR_DLAB] |=>
      hrdata_reg == $past(div_lo_reg))
    else $error("divisor latch not selected");
  rx_pop_a: assert property (
    rd_fire && sel == SEL_DATA && !empty[Q_RX] && !push[Q_RX] &&
      !flush[Q_RX] |=> count[Q_RX] == $past(count[Q_RX]) - 1'b1)
    else $error("receive pop missing");

  pop_cover_c: cover property (rd_fire && sel == SEL_DATA && !empty[Q_RX]);
  parity_cover_c: cover property (tx_state == TX_PAR);
  break_cover_c: cover property (brk && tx_state == TX_DATA);
  full_cover_c: cover property (full[Q_TX] && fifo_en_reg);
endmodule : uart_fifo_frame_ctrl
`default_nettype wire

// ### shared/uart_cfg_pkg.sv
// Shared constants and types for the serial port FIFO and framing control
package uart_cfg_pkg;

  // ==========================================================
  // Bus and register map (word indices, byte address = 4 x index)
  localparam int HADDR_W = 8;
  localparam int HDATA_W = 32;
  localparam int IDX_W = HADDR_W - 2;
  localparam logic [2:0] SIZE_WORD = 3'h2;
  localparam logic [IDX_W-1:0] IDX_DATA = 6'h00;
  localparam logic [IDX_W-1:0] IDX_DIV_HI = 6'h01;
  localparam logic [IDX_W-1:0] IDX_FIFO = 6'h02;
  localparam logic [IDX_W-1:0] IDX_FRAME = 6'h03;
  localparam logic [IDX_W-1:0] IDX_MODE = 6'h08;
  localparam logic [IDX_W-1:0] IDX_RX_COUNT = 6'h09;
  localparam logic [IDX_W-1:0] IDX_TX_COUNT = 6'h0A;

  // ==========================================================
  // Field positions
  localparam int FC_EN = 0;
  localparam int FC_RXCLR = 1;
  localparam int FC_TXCLR = 2;
  localparam int FC_TXLVL = 4;
  localparam int FC_RXLVL = 6;
  localparam int FR_LEN = 0;
  localparam int FR_STOP = 2;
  localparam int FR_PEN = 3;
  localparam int FR_EPS = 4;
  localparam int FR_STICK = 5;
  localparam int FR_BRK = 6;
  localparam int FR_DLAB = 7;
  localparam int MODE_ENH = 0;
  localparam int MODE_FIFO_ON = 1;

  // ==========================================================
  // Reset values and codes
  localparam logic [7:0] FRAME_RST = 8'h00;
  localparam logic [1:0] LVL_RST = 2'h0;
  localparam logic [7:0] DIV_LO_RST = 8'h10;
  localparam logic [7:0] DIV_HI_RST = 8'h00;
  localparam logic [15:0] DIV_MIN = 16'h0002;
  localparam logic [7:0] IIR_NONE = 8'hC1;
  localparam logic [7:0] IIR_RX_DATA = 8'hC4;
  localparam logic [1:0] LEN5 = 2'h0;
  localparam logic [2:0] DATA_MIN_LAST = 3'h4;
  localparam logic [2:0] STOP_HALF_ONE = 3'h2;
  localparam logic [2:0] STOP_HALF_ONE_HALF = 3'h3;
  localparam logic [2:0] STOP_HALF_TWO = 3'h4;

  // ==========================================================
  // Queue thresholds
  localparam logic [7:0] RX_STD_0 = 8'h01;
  localparam logic [7:0] RX_STD_1 = 8'h04;
  localparam logic [7:0] RX_STD_2 = 8'h08;
  localparam logic [7:0] RX_STD_3 = 8'h0E;
  localparam logic [7:0] RX_ENH_0 = 8'h0F;
  localparam logic [7:0] RX_ENH_1 = 8'h1F;
  localparam logic [7:0] RX_ENH_2 = 8'h3F;
  localparam logic [7:0] RX_ENH_3 = 8'h6F;
  localparam logic [7:0] TX_ENH_0 = 8'h10;
  localparam logic [7:0] TX_ENH_1 = 8'h20;
  localparam logic [7:0] TX_ENH_3 = 8'h70;
  localparam logic [7:0] TX_STD_LVL = 8'h00;
  localparam int Q_RX = 0;
  localparam int Q_TX = 1;

  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    SEL_NONE, SEL_DATA, SEL_DLL, SEL_DLM, SEL_FIFO, SEL_FRAME,
    SEL_MODE, SEL_RXCNT, SEL_TXCNT
  } reg_sel_e;
  typedef enum logic [2:0] {
    TX_IDLE, TX_LOAD, TX_START, TX_DATA, TX_PAR, TX_STOP
  } tx_state_e;
  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
  } rx_state_e;

endpackage : uart_cfg_pkg

// ### logic/fifo_mem.sv
// Queue storage with a registered read port
`timescale 1ns/1ps
`default_nettype none
module fifo_mem #(
  parameter int W = 8,
  parameter int DEPTH = 128,
  parameter int AW = 7
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);
  logic [W-1:0] mem [DEPTH];

  // Storage itself is not reset; only the read register is
  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (ce) begin
      rdata <= mem[raddr];
    end
  end
endmodule : fifo_mem
`default_nettype wire

// ### testbench/serial_peer.sv
// Remote serial peer: sends characters on rxd and decodes txd
`timescale 1ns/1ps
`default_nettype none
module serial_peer #(
  parameter int BT = 4
) (
  input wire logic clk,
  input wire logic txd,
  input wire logic listen,
  input wire logic [7:0] frame,
  output logic rxd,
  output logic got,
  output logic [9:0] word
);
  // ==========================================================
  // Sender: start, eight data bits LSB first, one stop; idles at mark
  initial begin
    rxd = 1'b1;
    got = 1'b0;
    word = '0;
  end
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (BT) @(posedge clk);
    end
  endtask : send
  // ==========================================================
  // Receiver
  // Samples the first cycle of every bit, so a long bit shows at once
  always begin
    @(posedge clk);
    got <= 1'b0;
    if (listen && txd === 1'b0) begin
      word = '0;
      for (int i = 0; i < 6 + frame[1:0] + frame[3]; i++) begin
        repeat (BT) @(posedge clk);
        word[i] = txd;
      end
      got <= 1'b1;
    end
  end
endmodule : serial_peer
`default_nettype wire

// ### testbench/testbench.sv
// Self-checking bench for the queue configuration and framing control
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import uart_cfg_pkg::*;
  localparam int BT = 4;
  logic clk, rst_n, ce, hsel, hwrite, hreadyout, hresp, rxd, txd, rpend;
  logic rx_trigger, tx_trigger, listen, got;
  logic [7:0] haddr, frame, v, d;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, brk;
  logic [9:0] word, e;
  logic [9:0] tx_q[$];
  logic [31:0] rd_q[$];
  int miscompares = 0;
  int tests_run = 0;
  int n;
  int lvl[8] = '{1, 4, 8, 14, 15, 31, 63, 111};
  int tl[4] = '{16, 32, 64, 112};
  logic [2:0] ptab[5] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h7};

  uart_fifo_frame_ctrl #(.TX_ENH_LVL_2(8'h40)) dut (.clk(clk), .rst_n(rst_n),
    .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rxd(rxd), .txd(txd),
    .rx_trigger(rx_trigger), .tx_trigger(tx_trigger));
  serial_peer #(.BT(BT)) peer (.clk(clk), .txd(txd), .listen(listen),
    .frame(frame), .rxd(rxd), .got(got), .word(word));

  // ==========================================================
  // Checking
  task automatic chk(input string s, input logic [31:0] x,
                     input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", s, x, g);
    end
  endtask : chk
  task automatic wrap_up;
    if (miscompares == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up
  // Read data is compared when its data phase completes
  always @(posedge clk) begin
    if (hreadyout === 1'b1) begin
      if (rpend) chk("hrdata", rd_q.pop_front(), hrdata);
      if (rpend) chk("hresp", 0, {31'h0, hresp});
      rpend <= hsel & htrans[1] & ~hwrite;
    end
    if (got) chk("serial word", tx_q.pop_front(), word);
  end
  // ==========================================================
  // Bus master
  task automatic bus(input logic w, input logic [5:0] i, input logic [7:0] b,
                     input logic [7:0] x);
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {i, 2'b00};
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h0, b};
    if (!w) rd_q.push_back({24'h0, x});
    do @(posedge clk); while (hreadyout !== 1'b1);
    if (w && i == IDX_FRAME) frame <= b;
  endtask : bus
  task automatic wr(input logic [5:0] i, input logic [7:0] b);
    bus(1'b1, i, b, 8'h00);
  endtask : wr
  task automatic rd(input logic [5:0] i, input logic [7:0] x);
    bus(1'b0, i, 8'($urandom), x);
  endtask : rd
  // ==========================================================
  // Clock, watchdog and sequence
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    wrap_up();
  end
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    hsel = 1'b1;
    haddr = '0;
    htrans = '0;
    hwrite = 1'b0;
    hsize = SIZE_WORD;
    hwdata = '0;
    listen = 1'b0;
    frame = '0;
    rpend = 1'b0;
    void'($urandom(32'h13F8C378));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(IDX_FRAME, 8'h00);
    rd(IDX_FIFO, 8'hC1);
    rd(IDX_MODE, 8'h00);
    wr(6'h3F, 8'hFF);
    rd(6'h3F, 8'h00);
    rd(IDX_DIV_HI, 8'h00);
    repeat (4) begin
      v = 8'($urandom) & 8'h7F;
      wr(IDX_FRAME, v);
      rd(IDX_FRAME, v);
    end
    // A byte-sized write must be ignored
    hsize <= 3'h0;
    wr(IDX_FRAME, 8'hFF);
    hsize <= SIZE_WORD;
    rd(IDX_FRAME, v);
    wr(IDX_FRAME, 8'h83);
    wr(IDX_DATA, 8'(BT));
    wr(IDX_DIV_HI, 8'h00);
    rd(IDX_DATA, 8'(BT));
    wr(IDX_FRAME, 8'h03);
    rd(IDX_DATA, 8'h00);
    wr(IDX_FIFO, 8'h01);
    rd(IDX_FIFO, 8'hC1);
    rd(IDX_MODE, 8'h02);
    // Every length with every parity choice, stop length random
    listen <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      v = {2'b00, ptab[i % 5], 1'($urandom), 2'(i / 5)};
      wr(IDX_FRAME, v);
      n = 5 + i / 5;
      d = 8'($urandom);
      wr(IDX_DATA, d);
      d = d & 8'((1 << n) - 1);
      e = {2'b00, d} | (10'h001 << (n + v[3]));
      if (v[3]) e[n] = v[5:4] == 2'b00 ? ~^d : v[5:4] == 2'b01 ? ^d : ~v[4];
      tx_q.push_back(e);
      for (int k = 0; k < 400 && tx_q.size() > 0; k++) @(posedge clk);
      repeat (3 * BT) @(posedge clk);
    end
    listen <= 1'b0;
    wr(IDX_FRAME, 8'h43);
    brk = '0;
    repeat (2) @(posedge clk);
    repeat (40) begin
      @(posedge clk);
      brk = brk | {31'h0, txd};
    end
    chk("break line", 32'h0, brk);
    wr(IDX_FRAME, 8'h03);
    repeat (3) @(posedge clk);
    chk("idle line", 32'h1, {31'h0, txd});
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    chk("hreadyout", 0, {31'h0, hreadyout});
    ce <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      wr(IDX_MODE, 8'(c / 4));
      wr(IDX_FIFO, {2'(c), 6'h03});
      for (int k = 0; k < lvl[c]; k++) begin
        if (k == lvl[c] - 1) chk("rx_trigger", 0, {31'h0, rx_trigger});
        peer.send(8'(k + 8'h5A));
        repeat (2 * BT) @(posedge clk);
      end
      chk("rx_trigger", 1, {31'h0, rx_trigger});
      rd(IDX_FIFO, 8'hC4);
      rd(IDX_RX_COUNT, 8'(lvl[c]));
      rd(IDX_DATA, 8'h5A);
      wr(IDX_FIFO, {2'(c), 6'h03});
      rd(IDX_RX_COUNT, 8'h00);
    end
    // A slow line keeps the first character in the shifter throughout
    wr(IDX_FRAME, 8'h83);
    wr(IDX_DIV_HI, 8'h04);
    rd(IDX_DIV_HI, 8'h04);
    wr(IDX_FRAME, 8'h03);
    for (int c = 0; c < 4; c++) begin
      wr(IDX_FIFO, {2'b00, 2'(c), 4'h5});
      repeat (tl[c]) wr(IDX_DATA, 8'($urandom));
      repeat (3) @(posedge clk);
      chk("tx_trigger", 1, {31'h0, tx_trigger});
      repeat (2) wr(IDX_DATA, 8'h00);
      repeat (3) @(posedge clk);
      chk("tx_trigger", 0, {31'h0, tx_trigger});
    end
    wr(IDX_FIFO, 8'h05);
    rd(IDX_TX_COUNT, 8'h00);
    wr(IDX_FIFO, 8'h00);
    rd(IDX_MODE, 8'h01);
    // Let the watcher take the last note before counting leftovers
    @(posedge clk);
    chk("read backlog", 0, rd_q.size());
    chk("serial backlog", 0, tx_q.size());
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
